// >>> src/scfd_pkg.sv
package scfd_pkg;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 16;
   localparam int DEV_W = 5;
   localparam int LEN_W = 8;
   localparam int FRAME_LEN_W = 9;
   localparam int FIFO_DEPTH = 32;
   localparam int MAX_DATA = 7;
   // Frame initialization byte fields
   localparam int KIND_BIT = 7;
   localparam int REQ_HI = 6;
   localparam int REQ_LO = 4;
   localparam int WIDE_BIT = 3;
   localparam int SIZE_HI = 2;
   localparam int SIZE_LO = 0;
   localparam int BCAST_BIT = 6;
   // One-byte response-size field
   localparam int RLEN_HI = 7;
   localparam int RLEN_LO = 5;
   localparam int HIGH_HI = 4;
   localparam int HIGH_LO = 0;
   localparam logic [2:0] REQ_GRP_RESP = 3'h2;
   localparam logic [2:0] REQ_GRP_NORESP = 3'h3;
   localparam logic [2:0] REQ_BC_RESP = 3'h6;
   localparam logic [2:0] REQ_BC_NORESP = 3'h7;
   localparam logic [ADDR_W-1:0] CMD_REG_ADDR = 16'h0002;
   // Init, CRC MSB and CRC LSB around the data bytes
   localparam logic [FRAME_LEN_W-1:0] RESP_OVERHEAD = 9'h003;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_TGT  = 3'h1,
      ST_ADRH = 3'h3,
      ST_ADRL = 3'h2,
      ST_DATA = 3'h6,
      ST_CRCH = 3'h7,
      ST_CRCL = 3'h5,
      ST_EXEC = 3'h4
   } scfd_state_t;
endpackage

// >>> src/scfd_stream_if.sv
`timescale 1ns/1ps
interface scfd_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> src/scfd_fifo.sv
`timescale 1ns/1ps
module scfd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic reset,
   scfd_stream_if.snk fill,
   scfd_stream_if.src drain
);
   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("scfd_fifo: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   logic push;
   logic pop;

   assign fill.ready = (count_q != (PW+1)'(DEPTH));
   assign drain.valid = (count_q != '0);
   assign drain.data = mem_q[rd_ptr_q];
   assign push = fill.valid && fill.ready;
   assign pop = drain.valid && drain.ready;

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_ptr_q] <= fill.data;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)
            rd_ptr_q <= rd_ptr_q + 1'b1;
         if (push && !pop)
            count_q <= count_q + 1'b1;
         else if (pop && !push)
            count_q <= count_q - 1'b1;
      end
   end

   fifo_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
      count_q <= (PW+1)'(DEPTH))
      else $error("fifo count beyond depth");
endmodule

// >>> src/scfd_decoder.sv
`timescale 1ns/1ps
// How it works
// - Command type 3 is group write, no reply.
// - No-reply writes never raise a response.
// - Matching group stores data in target register; type 2 does so only at the command register.
// - Address bit clear gives one address byte.
// - Address bit set adds address high byte.
// - One-byte size: top three length, low five highest.
// - Two-byte size: highest address, then length.
// - Broadcast has no target byte; all act.
// - Command register reply sized from channel select.
// - Type 6 is broadcast write with reply.
// - Low three init bits count data bytes.
// - Type 2 is group write with reply.
// - Replies run from highest address downward.
// - Each reply is init, data, two CRC.
module scfd_decoder #(
   parameter int FIFO_DEPTH = scfd_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [scfd_pkg::BYTE_W-1:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [scfd_pkg::BYTE_W-1:0] my_group_id,
   input wire logic [scfd_pkg::DEV_W-1:0] my_dev_addr,
   input wire logic [scfd_pkg::LEN_W-1:0] cmd_resp_len_m1,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [scfd_pkg::ADDR_W-1:0] wr_addr,
   output logic [scfd_pkg::BYTE_W-1:0] wr_data,
   output logic resp_start,
   output logic [scfd_pkg::LEN_W-1:0] resp_len_m1,
   output logic [scfd_pkg::DEV_W-1:0] resp_high,
   output logic [scfd_pkg::DEV_W-1:0] resp_wait,
   output logic [scfd_pkg::FRAME_LEN_W-1:0] resp_frame_len,
   output logic crc_err,
   output logic frame_done,
   output logic busy
);
   import scfd_pkg::*;

   scfd_stream_if #(.W(BYTE_W)) rx_if ();
   scfd_stream_if #(.W(BYTE_W)) dec_if ();

   assign rx_if.valid = rx_valid;
   assign rx_if.data = rx_data;
   assign rx_ready = rx_if.ready;

   scfd_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .fill(rx_if),
      .drain(dec_if)
   );

   scfd_state_t state_q;
   logic [BYTE_W-1:0] hdr_q;
   logic [BYTE_W-1:0] tgt_q;
   logic [ADDR_W-1:0] addr_q;
   logic [BYTE_W-1:0] buf_q [MAX_DATA];
   logic [2:0] idx_q;
   logic [2:0] widx_q;
   logic [15:0] crc_q;
   logic [BYTE_W-1:0] crc_hi_q;
   logic do_write_q;
   logic reply_q;
   logic [LEN_W-1:0] len_q;
   logic [DEV_W-1:0] high_q;

   logic [BYTE_W-1:0] in_byte;
   logic acc;
   logic [2:0] req;
   logic [2:0] size;
   logic wide;
   logic is_resp;
   logic to_cmd;
   logic targeted;
   logic crc_ok;
   logic [DEV_W-1:0] high_d;
   logic [LEN_W-1:0] len_d;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++)
         r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      return r;
   endfunction
   assign in_byte = dec_if.data;
   assign dec_if.ready = (state_q != ST_EXEC);
   assign acc = dec_if.valid && dec_if.ready;
   assign req = hdr_q[REQ_HI:REQ_LO];
   assign wide = hdr_q[WIDE_BIT];
   assign size = hdr_q[SIZE_HI:SIZE_LO];
   assign is_resp = (req == REQ_GRP_RESP) || (req == REQ_BC_RESP);
   assign to_cmd = (addr_q == CMD_REG_ADDR);
   assign crc_ok = ({crc_hi_q, in_byte} == crc_q);
   // Group types act on matching ID, broadcast on all, others ignored
   always_comb
   begin
      case (req)
         REQ_GRP_RESP, REQ_GRP_NORESP: targeted = (tgt_q == my_group_id);
         REQ_BC_RESP, REQ_BC_NORESP: targeted = 1'b1;
         default: targeted = 1'b0;
      endcase
   end
   // Highest responder and reply length from data bytes; command register length from cmd_resp_len_m1
   always_comb
   begin
      high_d = buf_q[0][HIGH_HI:HIGH_LO];
      if (to_cmd)
         len_d = cmd_resp_len_m1;
      else if (size == 3'h1)
         len_d = {5'h00, buf_q[0][RLEN_HI:RLEN_LO]};
      else
         len_d = buf_q[1];
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         state_q <= ST_IDLE;
      else
      begin
         case (state_q)
            ST_IDLE:
               if (acc && in_byte[KIND_BIT])
                  state_q <= in_byte[BCAST_BIT] ? (in_byte[WIDE_BIT] ? ST_ADRH : ST_ADRL)
                                                : ST_TGT;
            ST_TGT:
               if (acc)
                  state_q <= wide ? ST_ADRH : ST_ADRL;
            ST_ADRH:
               if (acc)
                  state_q <= ST_ADRL;
            ST_ADRL:
               if (acc)
                  state_q <= (size != 3'h0) ? ST_DATA : ST_CRCH;
            ST_DATA:
               if (acc && idx_q == size - 3'h1)
                  state_q <= ST_CRCH;
            ST_CRCH:
               if (acc)
                  state_q <= ST_CRCL;
            ST_CRCL:
               if (acc)
                  state_q <= (crc_ok && targeted) ? ST_EXEC : ST_IDLE;
            ST_EXEC:
               if (!wr_valid)
                  state_q <= ST_IDLE;
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
   // Captured header fields
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         hdr_q <= '0;
         tgt_q <= '0;
         addr_q <= '0;
         crc_hi_q <= '0;
      end
      else if (acc)
      begin
         case (state_q)
            ST_IDLE:
               if (in_byte[KIND_BIT])
               begin
                  hdr_q <= in_byte;
                  addr_q <= '0;
               end
            ST_TGT: tgt_q <= in_byte;
            ST_ADRH: addr_q[15:8] <= in_byte;
            ST_ADRL: addr_q[7:0] <= in_byte;
            ST_CRCH: crc_hi_q <= in_byte;
            default: ;
         endcase
      end
   end
   // Running CRC over all bytes ahead of the CRC field
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         crc_q <= CRC_INIT;
      else if (acc)
      begin
         if (state_q == ST_IDLE)
            crc_q <= crc_step(CRC_INIT, in_byte);
         else if (state_q != ST_CRCH && state_q != ST_CRCL)
            crc_q <= crc_step(crc_q, in_byte);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         idx_q <= '0;
      else if (state_q == ST_IDLE)
         idx_q <= '0;
      else if (acc && state_q == ST_DATA)
         idx_q <= idx_q + 3'h1;
   end

   genvar g;
   generate
      for (g = 0; g < MAX_DATA; g++)
      begin : g_buf
         always_ff @(posedge clk_sys)
         begin
            if (reset)
               buf_q[g] <= '0;
            else if (acc && state_q == ST_DATA && idx_q == 3'(g))
               buf_q[g] <= in_byte;
         end
      end
   endgenerate
   // Decision at the CRC check; writes deferred until frame is proven good
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         do_write_q <= 1'b0;
         reply_q <= 1'b0;
         len_q <= '0;
         high_q <= '0;
      end
      else if (acc && state_q == ST_CRCL)
      begin
         do_write_q <= !is_resp || to_cmd;
         reply_q <= is_resp && (my_dev_addr <= high_d);
         len_q <= len_d;
         high_q <= high_d;
      end
   end

   assign wr_valid = (state_q == ST_EXEC) && do_write_q && (widx_q < size);

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         widx_q <= '0;
         wr_addr <= '0;
         wr_data <= '0;
      end
      else if (acc && state_q == ST_CRCL)
      begin
         widx_q <= '0;
         wr_addr <= addr_q;
         wr_data <= buf_q[0];
      end
      else if (wr_valid && wr_ready)
      begin
         widx_q <= widx_q + 3'h1;
         wr_addr <= wr_addr + 16'h0001;
         wr_data <= (widx_q < 3'(MAX_DATA - 1)) ? buf_q[widx_q + 3'h1] : '0;
      end
   end
   // Reply descriptor, issued when the write phase ends
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         resp_start <= 1'b0;
         resp_len_m1 <= '0;
         resp_high <= '0;
         resp_wait <= '0;
         resp_frame_len <= '0;
      end
      else
      begin
         resp_start <= 1'b0;
         if (state_q == ST_EXEC && !wr_valid && reply_q)
         begin
            resp_start <= 1'b1;
            resp_len_m1 <= len_q;
            resp_high <= high_q;
            resp_wait <= high_q - my_dev_addr;
            resp_frame_len <= {1'b0, len_q} + RESP_OVERHEAD + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         crc_err <= 1'b0;
         frame_done <= 1'b0;
      end
      else
      begin
         crc_err <= acc && state_q == ST_CRCL && !crc_ok;
         frame_done <= state_q == ST_EXEC && !wr_valid;
      end
   end

   assign busy = (state_q != ST_IDLE);
   noreply_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
      resp_start |-> (req == REQ_GRP_RESP || req == REQ_BC_RESP))
      else $error("reply raised for a no-reply write");
   group_match_a: assert property (@(posedge clk_sys) disable iff (reset)
      (wr_valid && !hdr_q[BCAST_BIT]) |-> (tgt_q == my_group_id))
      else $error("write for a foreign group");
   narrow_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      (state_q == ST_DATA && !wide) |-> (addr_q[15:8] == 8'h00))
      else $error("high address byte set in narrow frame");
   wide_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
      (acc && state_q == ST_TGT && wide) |=> (state_q == ST_ADRH))
      else $error("wide address byte skipped");
   bcast_skip_a: assert property (@(posedge clk_sys) disable iff (reset)
      (acc && state_q == ST_IDLE && in_byte[KIND_BIT] && in_byte[BCAST_BIT])
      |=> (state_q != ST_TGT))
      else $error("broadcast frame expected target byte");
   cmd_len_a: assert property (@(posedge clk_sys) disable iff (reset)
      (resp_start && to_cmd) |-> (resp_len_m1 == cmd_resp_len_m1))
      else $error("command reply length not from channel select");
   one_byte_len_a: assert property (@(posedge clk_sys) disable iff (reset)
      (resp_start && !to_cmd && size == 3'h1)
      |-> (resp_len_m1 == {5'h00, buf_q[0][7:5]} && resp_high == buf_q[0][4:0]))
      else $error("one-byte size field misread");
   crc_drop_a: assert property (@(posedge clk_sys) disable iff (reset)
      (acc && state_q == ST_CRCL && !crc_ok) |=> (state_q == ST_IDLE) ##1 !resp_start)
      else $error("bad frame not dropped");
   reply_order_a: assert property (@(posedge clk_sys) disable iff (reset)
      resp_start |-> (resp_wait == resp_high - my_dev_addr && my_dev_addr <= resp_high))
      else $error("reply slot not counted from highest device");
   reply_len_a: assert property (@(posedge clk_sys) disable iff (reset)
      resp_start |-> (resp_frame_len == {1'b0, resp_len_m1} + 9'h004))
      else $error("reply frame length wrong");
endmodule

// >>> testbench/scfd_host_model.sv
`timescale 1ns/1ps
module scfd_host_model (
   input wire logic clk_sys,
   input wire logic reset,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   logic [7:0] q[$];
   logic took = 1'h0;
   logic stall = 1'h0;
   int seed = 38973;
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'h0;
   end
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask
   always @(posedge clk_sys)
      took <= rx_valid && rx_ready;
   // Offered byte holds until taken; idle line inverts the data bus on every idle cycle
   always @(negedge clk_sys)
   begin
      if (!(rx_valid && !took))
      begin
         if (!reset && q.size() > 0 && !(stall && ($random(seed) & 1)))
         begin
            rx_data <= q.pop_front();
            rx_valid <= 1'h1;
         end
         else
         begin
            rx_valid <= 1'h0;
            rx_data <= ~rx_data;
         end
      end
   end
endmodule

// >>> testbench/tb_scfd_decoder.sv
`timescale 1ns/1ps
module tb_scfd_decoder;
   import scfd_pkg::*;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_ready;
   logic [7:0] my_group_id = 8'h01;
   logic [4:0] my_dev_addr = 5'h01;
   logic [7:0] cmd_resp_len_m1 = 8'h05;
   logic wr_valid;
   logic wr_ready = 1'h0;
   logic [15:0] wr_addr;
   logic [7:0] wr_data;
   logic resp_start;
   logic [7:0] resp_len_m1;
   logic [4:0] resp_high;
   logic [4:0] resp_wait;
   logic [8:0] resp_frame_len;
   logic crc_err;
   logic frame_done;
   logic busy;
   logic hold = 1'h0;
   logic saw_full = 1'h0;
   logic [26:0] got_wr[$];
   logic [26:0] exp_wr[$];
   logic [26:0] got_rs[$];
   logic [26:0] exp_rs[$];
   logic [7:0] f[$];
   logic [31:0] t;
   int got_crc = 0;
   int exp_crc = 0;
   int got_done = 0;
   int exp_done = 0;
   int miscompares = 0;
   int samples_checked = 0;
   int seed = 38973;

   always #2 clk_sys = ~clk_sys;

   scfd_host_model host (.clk_sys(clk_sys), .reset(reset), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready));

   scfd_decoder uut (.clk_sys(clk_sys), .reset(reset), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .my_group_id(my_group_id),
      .my_dev_addr(my_dev_addr), .cmd_resp_len_m1(cmd_resp_len_m1),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .resp_start(resp_start), .resp_len_m1(resp_len_m1), .resp_high(resp_high),
      .resp_wait(resp_wait), .resp_frame_len(resp_frame_len), .crc_err(crc_err),
      .frame_done(frame_done), .busy(busy));

   always @(negedge clk_sys)
      wr_ready <= !hold && (($random(seed) & 3) != 0);

   always @(posedge clk_sys)
   begin
      if (!reset)
      begin
         if (wr_valid && wr_ready)
            got_wr.push_back({3'h0, wr_addr, wr_data});
         if (resp_start === 1'h1)
            got_rs.push_back({resp_len_m1, resp_high, resp_wait, resp_frame_len});
         if (crc_err === 1'h1)
            got_crc++;
         if (frame_done === 1'h1)
            got_done++;
         if (rx_ready === 1'h0)
            saw_full <= 1'h1;
      end
   end

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'h0000;
      foreach (b[i])
         for (int k = 7; k >= 0; k--)
            c = (c[15] ^ b[i][k]) ? {c[14:0], 1'h0} ^ 16'h8005 : {c[14:0], 1'h0};
      return c;
   endfunction

   // Expected writes and reply descriptor of one frame
   task automatic model(input logic [7:0] b[$], input bit bad);
      logic [2:0] typ;
      logic [15:0] a;
      logic [7:0] l;
      logic [4:0] h;
      int i;
      bit hit;
      typ = b[0][6:4];
      i = b[0][6] ? 1 : 2;
      hit = b[0][6] || b[1] === my_group_id;
      a = b[0][3] ? {b[i], b[i + 1]} : {8'h00, b[i]};
      i = i + (b[0][3] ? 2 : 1);
      if (!bad && hit && typ[1])
         exp_done++;
      if (bad)
         exp_crc++;
      else if (hit && (typ[1:0] == 2'h3 || (typ[1:0] == 2'h2 && a == CMD_REG_ADDR)))
         for (int j = 0; j < b[0][2:0]; j++)
            exp_wr.push_back({3'h0, a + 16'(j), b[i + j]});
      if (!bad && hit && typ[1:0] == 2'h2)
      begin
         h = b[i][4:0];
         l = b[0][2:0] == 3'h1 ? {5'h00, b[i][7:5]} : b[i + 1];
         if (a == CMD_REG_ADDR)
            l = cmd_resp_len_m1;
         if (my_dev_addr <= h)
            exp_rs.push_back({l, h, h - my_dev_addr, 9'(l) + 9'h004});
      end
   endtask

   task automatic frame(input logic [7:0] b[$], input bit bad, input bit settle);
      logic [15:0] c;
      int idle;
      c = crc16(b) ^ (bad ? 16'hFFFF : 16'h0000);
      model(b, bad);
      foreach (b[k])
         host.push(b[k]);
      host.push(c[15:8]);
      host.push(c[7:0]);
      idle = 0;
      for (int n = 0; n < 3000 && idle < 6 && settle; n++)
      begin
         @(posedge clk_sys);
         idle = (host.q.size() == 0 && !rx_valid && busy === 1'h0) ? idle + 1 : 0;
      end
      if (settle)
         cmp("frame settled", 6, idle);
   endtask

   task automatic cmp(input string what, input logic [26:0] e, input logic [26:0] g);
      samples_checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic end_test(input string name);
      cmp("write count", exp_wr.size(), got_wr.size());
      foreach (exp_wr[k])
         if (k < got_wr.size())
            cmp("write", exp_wr[k], got_wr[k]);
      cmp("reply count", exp_rs.size(), got_rs.size());
      foreach (exp_rs[k])
         if (k < got_rs.size())
            cmp("reply", exp_rs[k], got_rs[k]);
      cmp("crc errors", exp_crc, got_crc);
      cmp("frame done", exp_done, got_done);
      exp_wr = {};
      got_wr = {};
      exp_rs = {};
      got_rs = {};
      exp_crc = 0;
      got_crc = 0;
      exp_done = 0;
      got_done = 0;
      $display("test %s done", name);
   endtask

   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #100000;
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp("ready in reset", 1, rx_ready);
      cmp("busy in reset", 0, busy);
      cmp("write in reset", 0, wr_valid);
      cmp("reply in reset", 0, resp_start);
      reset <= 1'h0;
      frame('{8'hB1, 8'h01, 8'h07, 8'h7B}, 0, 1);
      frame('{8'hB1, 8'h05, 8'h07, 8'h7C}, 0, 1);
      end_test("group write");
      frame('{8'hA1, 8'h01, 8'h03, 8'h62}, 0, 1);
      frame('{8'hA2, 8'h01, 8'h03, 8'h02, 8'h03}, 0, 1);
      frame('{8'hE2, 8'h10, 8'h03, 8'h01}, 0, 1);
      frame('{8'hE1, 8'h10, 8'h22}, 0, 1);
      frame('{8'hE1, 8'h10, 8'h20}, 0, 1);
      end_test("replies");
      frame('{8'hA1, 8'h01, 8'h02, 8'h02}, 0, 1);
      frame('{8'hE1, 8'h02, 8'h03}, 0, 1);
      end_test("command register");
      host.push(8'h3C);
      frame('{8'hB9, 8'h01, 8'h12, 8'h34, 8'hAA}, 0, 1);
      frame('{8'h81, 8'h01, 8'h07, 8'h7B}, 0, 1);
      frame('{8'hC1, 8'h10, 8'h22}, 0, 1);
      frame('{8'hB3, 8'h01, 8'h10, 8'h11, 8'h22, 8'h33}, 0, 1);
      frame('{8'hF2, 8'hC8, 8'h44, 8'h55}, 0, 1);
      frame('{8'hB1, 8'h01, 8'h07, 8'h7B}, 1, 1);
      frame('{8'hA1, 8'h01, 8'h03, 8'h62}, 1, 1);
      end_test("layouts and crc");
      host.stall = 1'h1;
      for (int r = 0; r < 24; r++)
      begin
         t = $random(seed);
         @(negedge clk_sys);
         my_dev_addr = t[14:10];
         cmd_resp_len_m1 = t[22:15];
         f = {};
         f.push_back({1'h1, t[0], 1'h1, t[1], t[5], t[1] ? t[4:2] : (t[2] ? 3'h2 : 3'h1)});
         if (!t[0])
            f.push_back({7'h00, t[6]} + 8'h01);
         repeat (t[5] ? 2 : 1) f.push_back(8'($random(seed)));
         repeat (f[0][2:0]) f.push_back(8'($random(seed)));
         frame(f, t[9:7] == 3'h0, 1);
      end
      end_test("random frames");
      hold = 1'h1;
      host.stall = 1'h0;
      repeat (4) frame('{8'hB7, 8'h01, 8'h20, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
         8'h07}, 0, 0);
      for (int n = 0; n < 500 && !saw_full; n++)
         @(posedge clk_sys);
      cmp("fifo refused", 1, saw_full);
      @(negedge clk_sys);
      hold = 1'h0;
      frame('{8'hF1, 8'hC8, 8'h12}, 0, 1);
      cmp("fifo drained", 1, rx_ready);
      end_test("fifo full");
      report_and_stop();
   end
endmodule
